// [hdl/sfcd_params.svh]
`ifndef SFCD_PARAMS_SVH
`define SFCD_PARAMS_SVH
// ********************************
// opcodes
// ********************************
`define SFCD_OP_LATCH_SET 8'h06
`define SFCD_OP_LATCH_CLEAR 8'h04
`define SFCD_OP_STATUS_READ 8'h05
`define SFCD_OP_STATUS_WRITE 8'h01
`define SFCD_OP_READ 8'h03
`define SFCD_OP_FAST_READ 8'h0B
`define SFCD_OP_DUAL_READ 8'h3B
`define SFCD_OP_PROG 8'h02
`define SFCD_OP_PROG_ALT 8'hF2
`define SFCD_OP_SECTOR_ERASE 8'h20
`define SFCD_OP_BLOCK32_ERASE 8'h52
`define SFCD_OP_BLOCK64_ERASE 8'hD8
`define SFCD_OP_CHIP_ERASE_A 8'hC7
`define SFCD_OP_CHIP_ERASE_B 8'h60
`define SFCD_OP_POWER_DOWN 8'hB9
// ********************************
// status byte layout and reset values
// ********************************
`define SFCD_ST_LOCK 7
`define SFCD_ST_RSV_HI 6
`define SFCD_ST_RSV_LO 5
`define SFCD_ST_BP_HI 4
`define SFCD_ST_BP_LO 2
`define SFCD_ST_LATCH 1
`define SFCD_ST_BUSY 0
`define SFCD_LOCK_RST 1'b0
`define SFCD_BP_RST 3'h0
// ********************************
// framing counts and sync lanes
// ********************************
`define SFCD_LAST_BIT 3'h7
`define SFCD_BYTES_OPCODE 3'h1
`define SFCD_BYTES_SW_MIN 3'h2
`define SFCD_BYTES_SW_MAX 3'h3
`define SFCD_BYTES_ADDR 3'h4
`define SFCD_BYTES_PROG_MIN 3'h5
`define SFCD_FALLS_SINGLE 3'h7
`define SFCD_FALLS_DUAL 3'h3
`define SFCD_UNDERRUN_BYTE 8'hFF
`define SFCD_SY_CS 3
`define SFCD_SY_CK 2
`define SFCD_SY_SI 1
`define SFCD_SY_WG 0
`define SFCD_SY_RST 4'h9
// ********************************
// timing
// ********************************
`define SFCD_CLK_NS 20
`define SFCD_TW_NS 5000000
`define SFCD_TW_CYCLES (`SFCD_TW_NS / `SFCD_CLK_NS)
`endif

// [hdl/sfcd_pkg.sv]
package sfcd_pkg;
  typedef logic [7:0] sfcd_byte_t;
  typedef logic [23:0] sfcd_addr_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DATA_OUT = 3'h6,
    ST_DATA_IN = 3'h7,
    ST_HOLD = 3'h5,
    ST_IGNORE = 3'h4
  } sfcd_state_e;
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic cs_prev;
    logic sclk_prev;
    sfcd_state_e state;
    sfcd_byte_t opcode;
    sfcd_byte_t shift_in;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    sfcd_addr_t addr;
    sfcd_byte_t shift_out;
    logic [2:0] out_cnt;
    logic dual;
    logic from_status;
    logic odd_out;
    logic odd_oe;
    logic even_out;
    logic even_oe;
    logic write_enable_latch;
    logic busy;
    logic sw_busy;
    logic [23:0] timer;
    logic lock;
    logic [2:0] bp;
    sfcd_byte_t sw_new;
    logic hw_lock;
    sfcd_byte_t status_out;
    sfcd_addr_t rd_addr;
    sfcd_addr_t req_addr;
    logic rd_req;
    logic pending;
    logic drop;
    logic pop;
    logic flush;
    sfcd_byte_t prog_data;
    logic prog_valid;
    logic op_start;
    sfcd_byte_t op_code;
    sfcd_addr_t op_addr;
  } sfcd_core_s;
endpackage : sfcd_pkg

// [hdl/sfcd_buf2.sv]
`timescale 1ns/100ps
`default_nettype none
module sfcd_buf2 #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2,
  parameter int unsigned CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic full;
  } sfcd_buf_s;
  sfcd_buf_s r;
  sfcd_buf_s n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pull;
  assign push = in_valid & ~r.full & ~flush;
  assign pull = out_ready & (r.cnt != '0) & ~flush;
  assign in_ready = ~r.full;
  assign out_valid = (r.cnt != '0);
  assign out_data = mem[r.rd];
  assign count = r.cnt;
  always_comb begin
    n = r;
    if (flush) begin
      n = '0;
    end else begin
      if (push) begin
        n.wr = (r.wr == PW'(DEPTH - 1)) ? '0 : PW'(r.wr + 1'b1);
      end
      if (pull) begin
        n.rd = (r.rd == PW'(DEPTH - 1)) ? '0 : PW'(r.rd + 1'b1);
      end
      if (push && !pull) begin
        n.cnt = CW'(r.cnt + 1'b1);
      end else if (pull && !push) begin
        n.cnt = CW'(r.cnt - 1'b1);
      end
      n.full = (n.cnt == CW'(DEPTH));
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  // storage has no reset, contents only matter once counted
  always_ff @(posedge clk) begin
    if (push) begin
      mem[r.wr] <= in_data;
    end
  end
endmodule : sfcd_buf2
`default_nettype wire

// [hdl/sfcd_core.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sfcd_params.svh"
// ********************************
// serial flash command decoder
// ********************************
// Operation
// - bits travel msb first, sampled on rising clock after select falls
// - each transfer opens with an eight-bit opcode, then address/data or none
// - read-type transfers may end after any output bit; outputs released
// - write-type commands run only if select rises on a byte boundary
// - page program with partial last byte does nothing, latch stays set
// - framed 06H sets the write-enable latch
// - program, erases, status write need the latch set
// - framed 04H clears the write-enable latch
// - latch clears at reset and when any write operation completes
// - status read 05H accepted anytime, even while busy
// - status byte repeats while clocks continue, busy refreshed each time
// - status write keeps S6 S5 S1 S0; S6 S5 read zero
// - status write runs only after eighth or sixteenth data bit
// - status write starts timed cycle, busy high, then busy and latch clear
// - status write loads protect bits and lock; refused in hardware lock
// - hardware lock when lock bit set and write guard low
// - 03H plus address streams bytes on falling edges, address increments
// - reads while busy are rejected, running cycle undisturbed
// - 0BH takes address and a dummy byte before data out
// - 3BH drives odd bits on odd pin, even bits on even pin
// - erases 20H 52H D8H take three address bytes, no data
// - 02H takes address then data; C7H or 60H alone erase chip
module sfcd_core #(
  parameter int unsigned TW_CYCLES = `SFCD_TW_CYCLES,
  parameter int unsigned BUF_DEPTH = 2,
  parameter int unsigned CW = $clog2(BUF_DEPTH + 1)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dual_pin_even_in,
  output logic dual_pin_even_out,
  output logic dual_pin_even_oe,
  output logic dual_pin_odd_out,
  output logic dual_pin_odd_oe,
  input wire logic write_guard_n,
  output sfcd_pkg::sfcd_addr_t mem_rd_addr,
  output logic mem_rd_req,
  input wire sfcd_pkg::sfcd_byte_t mem_rd_data,
  input wire logic mem_rd_valid,
  output logic mem_rd_ready,
  output sfcd_pkg::sfcd_byte_t prog_data,
  output logic prog_data_valid,
  output logic op_start,
  output sfcd_pkg::sfcd_byte_t op_code,
  output sfcd_pkg::sfcd_addr_t op_addr,
  input wire logic op_done,
  output sfcd_pkg::sfcd_byte_t status_byte,
  output logic hardware_lock_mode
);
  import sfcd_pkg::*;

  sfcd_core_s r;
  sfcd_core_s n;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  sfcd_byte_t byte_in;
  sfcd_byte_t status_now;
  logic buf_in_ready;
  logic buf_out_valid;
  sfcd_byte_t buf_out_data;
  logic [CW-1:0] buf_count;

  // ********************************
  // edges of the synchronised pins
  // ********************************
  assign cs_rise = r.sync[`SFCD_SY_CS] & ~r.cs_prev;
  assign cs_fall = ~r.sync[`SFCD_SY_CS] & r.cs_prev;
  assign sclk_rise = r.sync[`SFCD_SY_CK] & ~r.sclk_prev;
  assign sclk_fall = ~r.sync[`SFCD_SY_CK] & r.sclk_prev;
  assign byte_in = {r.shift_in[6:0], r.sync[`SFCD_SY_SI]};

  always_comb begin
    status_now = '0;
    status_now[`SFCD_ST_LOCK] = r.lock;
    status_now[`SFCD_ST_BP_HI:`SFCD_ST_BP_LO] = r.bp;
    status_now[`SFCD_ST_LATCH] = r.write_enable_latch;
    status_now[`SFCD_ST_BUSY] = r.busy;
  end

  // ********************************
  // read data buffer
  // ********************************
  sfcd_buf2 #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH),
    .CW(CW)
  ) i_sfcd_buf2 (
    .clk(sys_clk),
    .rst(rst),
    .flush(r.flush),
    .in_valid(mem_rd_valid & ~r.drop),
    .in_ready(buf_in_ready),
    .in_data(mem_rd_data),
    .out_valid(buf_out_valid),
    .out_ready(r.pop),
    .out_data(buf_out_data),
    .count(buf_count)
  );

  // ********************************
  // next state
  // ********************************
  always_comb begin
    sfcd_byte_t cur;
    logic start;
    cur = r.shift_out;
    start = 1'b0;
    n = r;
    n.meta = {cs_n, sclk, dual_pin_even_in, write_guard_n};
    n.sync = r.meta;
    n.cs_prev = r.sync[`SFCD_SY_CS];
    n.sclk_prev = r.sync[`SFCD_SY_CK];
    n.rd_req = 1'b0;
    n.pop = 1'b0;
    n.flush = 1'b0;
    n.prog_valid = 1'b0;
    n.op_start = 1'b0;
    n.hw_lock = r.lock & ~r.sync[`SFCD_SY_WG];
    n.status_out = status_now;
    // busy ends either by own timer or by the array engine
    if (r.sw_busy) begin
      if (r.timer == 24'(TW_CYCLES - 1)) begin
        n.sw_busy = 1'b0;
        n.busy = 1'b0;
        n.write_enable_latch = 1'b0;
      end else begin
        n.timer = 24'(r.timer + 1'b1);
      end
    end else if (r.busy && op_done) begin
      n.busy = 1'b0;
      n.write_enable_latch = 1'b0;
    end
    if (mem_rd_valid && buf_in_ready && r.pending) begin
      n.pending = 1'b0;
      n.drop = 1'b0;
    end
    if (cs_rise) begin
      n.state = ST_IDLE;
      n.odd_oe = 1'b0;
      n.even_oe = 1'b0;
      n.flush = 1'b0 | (r.state != ST_IDLE);
      // a fetch still in flight is swallowed when it lands
      n.drop = n.pending;
      if (r.state != ST_IGNORE && r.state != ST_IDLE && r.bit_cnt == 3'h0) begin
        case (r.opcode)
          `SFCD_OP_LATCH_SET: begin
            if (r.byte_cnt == `SFCD_BYTES_OPCODE) begin
              n.write_enable_latch = 1'b1;
            end
          end
          `SFCD_OP_LATCH_CLEAR: begin
            if (r.byte_cnt == `SFCD_BYTES_OPCODE) begin
              n.write_enable_latch = 1'b0;
            end
          end
          `SFCD_OP_STATUS_WRITE: begin
            if ((r.byte_cnt == `SFCD_BYTES_SW_MIN || r.byte_cnt == `SFCD_BYTES_SW_MAX)
                && r.write_enable_latch && !r.hw_lock) begin
              n.lock = r.sw_new[`SFCD_ST_LOCK];
              n.bp = r.sw_new[`SFCD_ST_BP_HI:`SFCD_ST_BP_LO];
              n.busy = 1'b1;
              n.sw_busy = 1'b1;
              n.timer = '0;
            end
          end
          `SFCD_OP_PROG, `SFCD_OP_PROG_ALT: begin
            start = (r.byte_cnt >= `SFCD_BYTES_PROG_MIN) && r.write_enable_latch;
          end
          `SFCD_OP_SECTOR_ERASE, `SFCD_OP_BLOCK32_ERASE, `SFCD_OP_BLOCK64_ERASE: begin
            start = (r.byte_cnt == `SFCD_BYTES_ADDR) && r.write_enable_latch;
          end
          `SFCD_OP_CHIP_ERASE_A, `SFCD_OP_CHIP_ERASE_B: begin
            start = (r.byte_cnt == `SFCD_BYTES_OPCODE) && r.write_enable_latch;
          end
          `SFCD_OP_POWER_DOWN: begin
            if (r.byte_cnt == `SFCD_BYTES_OPCODE) begin
              n.op_start = 1'b1;
              n.op_code = r.opcode;
            end
          end
          default: begin
          end
        endcase
        if (start) begin
          n.op_start = 1'b1;
          n.op_code = r.opcode;
          n.op_addr = r.addr;
          n.busy = 1'b1;
        end
      end
    end else if (cs_fall) begin
      n.state = ST_OPCODE;
      n.bit_cnt = 3'h0;
      n.byte_cnt = 3'h0;
      n.out_cnt = 3'h0;
      n.dual = 1'b0;
      n.from_status = 1'b0;
    end else if (!r.sync[`SFCD_SY_CS] && r.state != ST_IDLE) begin
      if (sclk_rise) begin
        n.shift_in = byte_in;
        n.bit_cnt = 3'(r.bit_cnt + 1'b1);
        if (r.bit_cnt == `SFCD_LAST_BIT) begin
          if (r.byte_cnt != 3'h7) begin
            n.byte_cnt = 3'(r.byte_cnt + 1'b1);
          end
          case (r.state)
            ST_OPCODE: begin
              n.opcode = byte_in;
              if (r.busy && byte_in != `SFCD_OP_STATUS_READ) begin
                n.state = ST_IGNORE;
              end else begin
                case (byte_in)
                  `SFCD_OP_STATUS_READ: begin
                    n.state = ST_DATA_OUT;
                    n.from_status = 1'b1;
                  end
                  `SFCD_OP_LATCH_SET, `SFCD_OP_LATCH_CLEAR, `SFCD_OP_CHIP_ERASE_A,
                  `SFCD_OP_CHIP_ERASE_B, `SFCD_OP_POWER_DOWN: begin
                    n.state = ST_HOLD;
                  end
                  `SFCD_OP_STATUS_WRITE: begin
                    n.state = ST_DATA_IN;
                  end
                  `SFCD_OP_READ, `SFCD_OP_FAST_READ, `SFCD_OP_DUAL_READ, `SFCD_OP_PROG,
                  `SFCD_OP_PROG_ALT, `SFCD_OP_SECTOR_ERASE, `SFCD_OP_BLOCK32_ERASE,
                  `SFCD_OP_BLOCK64_ERASE: begin
                    n.state = ST_ADDR;
                    n.dual = (byte_in == `SFCD_OP_DUAL_READ);
                  end
                  default: begin
                    n.state = ST_IGNORE;
                  end
                endcase
              end
            end
            ST_ADDR: begin
              n.addr = {r.addr[15:0], byte_in};
              if (r.byte_cnt == `SFCD_BYTES_SW_MAX) begin
                n.rd_addr = {r.addr[15:0], byte_in};
                case (r.opcode)
                  `SFCD_OP_READ: begin
                    n.state = ST_DATA_OUT;
                  end
                  `SFCD_OP_FAST_READ, `SFCD_OP_DUAL_READ: begin
                    n.state = ST_DUMMY;
                  end
                  `SFCD_OP_PROG, `SFCD_OP_PROG_ALT: begin
                    n.state = ST_DATA_IN;
                  end
                  default: begin
                    n.state = ST_HOLD;
                  end
                endcase
              end
            end
            ST_DUMMY: begin
              n.state = ST_DATA_OUT;
            end
            ST_DATA_IN: begin
              if (r.opcode == `SFCD_OP_STATUS_WRITE) begin
                if (r.byte_cnt == `SFCD_BYTES_OPCODE) begin
                  n.sw_new = byte_in;
                end
              end else begin
                n.prog_data = byte_in;
                n.prog_valid = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      if (sclk_fall && r.state == ST_DATA_OUT) begin
        if (r.out_cnt == 3'h0) begin
          // status is sampled fresh for every repeat
          if (r.from_status) begin
            cur = status_now;
          end else if (buf_out_valid) begin
            cur = buf_out_data;
            n.pop = 1'b1;
          end else begin
            cur = `SFCD_UNDERRUN_BYTE;
          end
          n.out_cnt = r.dual ? `SFCD_FALLS_DUAL : `SFCD_FALLS_SINGLE;
        end else begin
          n.out_cnt = 3'(r.out_cnt - 1'b1);
        end
        n.odd_out = cur[7];
        n.odd_oe = 1'b1;
        n.even_out = cur[6];
        n.even_oe = r.dual;
        n.shift_out = r.dual ? {cur[5:0], 2'b00} : {cur[6:0], 1'b0};
      end
      // keep the buffer topped up while an array read streams
      if ((r.state == ST_DUMMY || r.state == ST_DATA_OUT) && !r.from_status
          && !r.pending && !r.busy && buf_count < CW'(BUF_DEPTH)) begin
        n.rd_req = 1'b1;
        n.pending = 1'b1;
        n.req_addr = r.rd_addr;
        n.rd_addr = 24'(r.rd_addr + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      r.meta <= `SFCD_SY_RST;
      r.sync <= `SFCD_SY_RST;
      r.cs_prev <= 1'b1;
      r.state <= ST_IDLE;
      r.lock <= `SFCD_LOCK_RST;
      r.bp <= `SFCD_BP_RST;
      r.write_enable_latch <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign dual_pin_even_out = r.even_out;
  assign dual_pin_even_oe = r.even_oe;
  assign dual_pin_odd_out = r.odd_out;
  assign dual_pin_odd_oe = r.odd_oe;
  assign mem_rd_addr = r.req_addr;
  assign mem_rd_req = r.rd_req;
  assign mem_rd_ready = buf_in_ready;
  assign prog_data = r.prog_data;
  assign prog_data_valid = r.prog_valid;
  assign op_start = r.op_start;
  assign op_code = r.op_code;
  assign op_addr = r.op_addr;
  assign status_byte = r.status_out;
  assign hardware_lock_mode = r.hw_lock;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_latch_set;
    cs_rise && r.state == ST_HOLD && r.opcode == `SFCD_OP_LATCH_SET
      && r.byte_cnt == `SFCD_BYTES_OPCODE && r.bit_cnt == 3'h0 |=> r.write_enable_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_latch_clear;
    cs_rise && r.state == ST_HOLD && r.opcode == `SFCD_OP_LATCH_CLEAR
      && r.byte_cnt == `SFCD_BYTES_OPCODE && r.bit_cnt == 3'h0 |=> !r.write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

  property p_unframed;
    cs_rise && r.bit_cnt != 3'h0 && !r.busy |=> !r.op_start && !r.busy && $stable(r.write_enable_latch);
  endproperty
  a_unframed: assert property (p_unframed) else $error("unframed command ran");

  property p_release;
    cs_rise |=> !r.odd_oe && !r.even_oe && r.state == ST_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("outputs held after select");

  property p_reserved_zero;
    r.status_out[`SFCD_ST_RSV_HI:`SFCD_ST_RSV_LO] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_sw_end;
    $fell(r.sw_busy) |-> !r.busy && !r.write_enable_latch;
  endproperty
  a_sw_end: assert property (p_sw_end) else $error("timed cycle end wrong");

  property p_no_read_busy;
    r.busy |-> !r.rd_req;
  endproperty
  a_no_read_busy: assert property (p_no_read_busy) else $error("array read while busy");

  property p_lock_hold;
    r.hw_lock && !cs_rise |=> $stable(r.lock) && $stable(r.bp);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked bits changed");

  property p_msb_first;
    sclk_fall && r.state == ST_DATA_OUT && r.out_cnt != 3'h0 && !cs_rise && !cs_fall
      |=> r.odd_out == $past(r.shift_out[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit order wrong");
endmodule : sfcd_core
`default_nettype wire

// [testbench/sfcd_host.sv]
`timescale 1ns/100ps
`default_nettype none
// ********************************
// host link controller model
// ********************************
module sfcd_host (
  input wire logic sys_clk,
  output var logic sclk,
  output var logic cs_n,
  output var logic si,
  input wire logic odd_out,
  input wire logic odd_oe,
  input wire logic even_out,
  input wire logic even_oe
);
  logic oe_seen;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    oe_seen = 1'b0;
  end
  // idle data line toggles so a stale bit never reads as valid
  always @(posedge sys_clk) begin
    if (cs_n) si <= ~si;
  end
  // mode 0, 8 sys_clk per link clock, far below the read limit
  task automatic xfer(input logic [63:0] tx, input int nb, input int nr, input bit dual,
                      output logic [31:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < nb + nr; i++) begin
      sclk <= 1'b0;
      if (i < nb) si <= tx[63-i];
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (3) @(posedge sys_clk);
      oe_seen = oe_seen | odd_oe | even_oe;
      if (i >= nb) rx = dual ? {rx[29:0], odd_out, even_out} : {rx[30:0], odd_out};
      @(posedge sys_clk);
    end
    sclk <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask : xfer
endmodule : sfcd_host
`default_nettype wire

// [testbench/serial_flash_command_decoder_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_flash_command_decoder_tb;
  import sfcd_pkg::*;
  logic sys_clk, rst, write_guard_n, op_done, mem_rd_valid, mem_rd_req, mem_rd_ready;
  logic sclk, cs_n, si, even_out, even_oe, odd_out, odd_oe;
  logic prog_data_valid, op_start, hardware_lock_mode;
  sfcd_byte_t mem_rd_data, prog_data, op_code, status_byte;
  sfcd_addr_t mem_rd_addr, op_addr;
  logic [31:0] rx;
  int fails, comparisons, starts, progs, reqs, n, c0, p0;
  logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  // ********************************
  // design, host and array models
  // ********************************
  sfcd_core #(.TW_CYCLES(40)) i_sfcd_core (
    .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .dual_pin_even_in(si),
    .dual_pin_even_out(even_out), .dual_pin_even_oe(even_oe),
    .dual_pin_odd_out(odd_out), .dual_pin_odd_oe(odd_oe), .write_guard_n(write_guard_n),
    .mem_rd_addr(mem_rd_addr), .mem_rd_req(mem_rd_req), .mem_rd_data(mem_rd_data),
    .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready), .prog_data(prog_data),
    .prog_data_valid(prog_data_valid), .op_start(op_start), .op_code(op_code),
    .op_addr(op_addr), .op_done(op_done), .status_byte(status_byte),
    .hardware_lock_mode(hardware_lock_mode));
  sfcd_host i_host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .si(si), .odd_out(odd_out),
    .odd_oe(odd_oe), .even_out(even_out), .even_oe(even_oe));
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  // array answers one cycle after a request; idle data toggles
  always @(posedge sys_clk) begin
    if (op_start) starts <= starts + 1;
    if (prog_data_valid) progs <= progs + 1;
    if (mem_rd_req) reqs <= reqs + 1;
    if (mem_rd_req) begin
      mem_rd_data <= mem_rd_addr[7:0] ^ 8'hA5;
      mem_rd_valid <= 1'b1;
    end else if (mem_rd_valid && mem_rd_ready) begin
      mem_rd_valid <= 1'b0;
    end else if (!mem_rd_valid) begin
      mem_rd_data <= ~mem_rd_data;
    end
  end
  // ********************************
  // tasks
  // ********************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stat(input logic [7:0] e);
    i_host.xfer({8'h05, 56'h0}, 8, 16, 1'b0, rx);
    check("status_read", rx, {16'h0, e, e});
    check("status_port", {24'h0, status_byte}, {24'h0, e});
  endtask : stat
  task automatic done();
    @(posedge sys_clk);
    op_done <= 1'b1;
    @(posedge sys_clk);
    op_done <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : done
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // ********************************
  // tests
  // ********************************
  initial begin
    rst = 1'b1;
    write_guard_n = 1'b1;
    op_done = 1'b0;
    mem_rd_valid = 1'b0;
    mem_rd_data = 8'h00;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    stat(8'h00);
    i_host.xfer({8'h06, 56'h0}, 8, 0, 1'b0, rx);
    stat(8'h02);
    i_host.xfer({8'h04, 56'h0}, 8, 0, 1'b0, rx);
    stat(8'h00);
    i_host.xfer({8'h06, 56'h0}, 9, 0, 1'b0, rx);
    stat(8'h00);
    i_host.xfer({8'h20, 24'h001000, 32'h0}, 32, 0, 1'b0, rx);
    check("erase_no_latch", starts, 0);
    foreach (ops[k]) begin
      i_host.xfer({8'h06, 56'h0}, 8, 0, 1'b0, rx);
      n = (ops[k] == 8'hC7 || ops[k] == 8'h60) ? 8 : 32;
      i_host.xfer({ops[k], 24'h0A0B0C, 32'h0}, n, 0, 1'b0, rx);
      check("op_code", {24'h0, op_code}, {24'h0, ops[k]});
      check("op_count", starts, k + 1);
      if (n == 32) check("op_addr", {8'h0, op_addr}, 32'h000A_0B0C);
      stat(8'h03);
      c0 = reqs;
      i_host.xfer({8'h03, 24'h0, 32'h0}, 32, 8, 1'b0, rx);
      check("busy_read", reqs - c0, 0);
      check("busy_read_oe", {31'h0, i_host.oe_seen}, 0);
      done();
      stat(8'h00);
    end
    i_host.xfer({8'h06, 56'h0}, 8, 0, 1'b0, rx);
    c0 = starts;
    i_host.xfer({8'h02, 24'h000100, 8'h3C, 8'hC3, 16'h0}, 43, 0, 1'b0, rx);
    check("partial_prog", starts - c0, 0);
    stat(8'h02);
    p0 = progs;
    i_host.xfer({8'h02, 24'h000100, 8'h3C, 8'hC3, 16'h0}, 48, 0, 1'b0, rx);
    check("prog_start", starts - c0, 1);
    check("prog_bytes", progs - p0, 2);
    check("prog_data", {prog_data, op_addr}, {8'hC3, 24'h000100});
    done();
    stat(8'h00);
    i_host.xfer({8'h06, 56'h0}, 8, 0, 1'b0, rx);
    i_host.xfer({8'h01, 8'hFF, 48'h0}, 16, 0, 1'b0, rx);
    check("sw_busy", {31'h0, status_byte[0]}, 1);
    repeat (60) @(posedge sys_clk);
    stat(8'h9C);
    write_guard_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("hw_lock", {31'h0, hardware_lock_mode}, 1);
    i_host.xfer({8'h06, 56'h0}, 8, 0, 1'b0, rx);
    i_host.xfer({8'h01, 8'h00, 48'h0}, 16, 0, 1'b0, rx);
    repeat (60) @(posedge sys_clk);
    stat(8'h9E);
    write_guard_n <= 1'b1;
    i_host.xfer({8'h01, 8'h00, 48'h0}, 20, 0, 1'b0, rx);
    repeat (60) @(posedge sys_clk);
    stat(8'h9E);
    i_host.xfer({8'h01, 16'h0000, 40'h0}, 24, 0, 1'b0, rx);
    repeat (60) @(posedge sys_clk);
    stat(8'h00);
    i_host.xfer({8'h03, 24'h0000FE, 32'h0}, 32, 20, 1'b0, rx);
    check("read", rx, 32'h0005_B5AA);
    check("read_release", {31'h0, odd_oe}, 0);
    i_host.xfer({8'h0B, 24'h123456, 32'h0}, 40, 16, 1'b0, rx);
    check("fast_read", rx, 32'h0000_F3F2);
    i_host.xfer({8'h3B, 24'h000010, 32'h0}, 40, 8, 1'b1, rx);
    check("dual_read", rx, 32'h0000_B5B4);
    i_host.xfer({8'hAA, 56'h0}, 8, 16, 1'b0, rx);
    check("unknown_oe", {31'h0, i_host.oe_seen}, 0);
    stat(8'h00);
    results();
  end
  initial begin
    repeat (50000) @(posedge sys_clk);
    fails++;
    results();
  end
endmodule : serial_flash_command_decoder_tb
`default_nettype wire
